// >>> core/eida_top.sv
// external interrupt detection, flags and acknowledge strobe
`timescale 1ns/100ps
`include "eida_defines.svh"

module eida_top
#(
    parameter int NUM_IRQ = `EIDA_NUM_IRQ
)
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire eida_pkg::eida_vec_t ext_irq_n,
    input  wire eida_pkg::eida_vec_t edge_detect_select,
    input  wire eida_pkg::eida_vec_t flag_clr,
    input  wire eida_pkg::eida_vec_t cpu_irq_enable,
    input  wire eida_pkg::eida_vec_t dma_irq_enable,
    input  wire logic                cpu_fetch_boundary,
    input  wire logic                dma_fetch_boundary,
    input  wire logic                ack_decode_start,
    input  wire logic                ack_read_start,
    output eida_pkg::eida_vec_t      irq_flag,
    output eida_pkg::eida_vec_t      irq_overrun,
    output logic                     cpu_irq_req,
    output eida_pkg::eida_id_t       cpu_irq_id,
    output logic                     dma_irq_req,
    output eida_pkg::eida_id_t       dma_irq_id,
    output logic                     irq_ack_strobe_n
);

    // the block is built for the documented pin count only
    if (NUM_IRQ != `EIDA_NUM_IRQ)
    begin : g_bad_count
        $error("eida_top: NUM_IRQ must equal the pin count");
    end

    // lowest pending index wins; used for the cpu and the dma
    function automatic eida_pkg::eida_id_t eida_first
    (
        input eida_pkg::eida_vec_t vec
    );
        eida_pkg::eida_id_t id;
        id = '0;
        for (int i = `EIDA_NUM_IRQ - 1; i >= 0; i--)
        begin
            if (vec[i])
                id = eida_pkg::eida_id_t'(i);
        end
        return id;
    endfunction : eida_first

    // any bit set; used for the cpu and the dma
    function automatic logic eida_any
    (
        input eida_pkg::eida_vec_t vec
    );
        return |vec;
    endfunction : eida_any

    eida_pin_if pins ();

    eida_pkg::eida_vec_t flag_reg;
    eida_pkg::eida_vec_t flag_next;
    eida_pkg::eida_vec_t overrun_reg;
    eida_pkg::eida_vec_t overrun_next;
    eida_pkg::eida_vec_t detect;
    eida_pkg::eida_vec_t cpu_pend;
    eida_pkg::eida_vec_t dma_pend;
    logic                cpu_req_reg;
    eida_pkg::eida_id_t  cpu_id_reg;
    logic                dma_req_reg;
    eida_pkg::eida_id_t  dma_id_reg;
    eida_pkg::eida_ack_e ack_state_reg;
    eida_pkg::eida_ack_e ack_state_next;
    logic                strobe_n_reg;
    logic                strobe_n_next;

    // pin synchroniser and transition finder
    eida_sampler u_sampler
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ext_irq_n (ext_irq_n),
        .pins      (pins)
    );

    // per-pin detection: either the low level or a found fall
    always_comb
    begin
        for (int i = 0; i < `EIDA_NUM_IRQ; i++)
        begin
            if (edge_detect_select[i])
                detect[i] = pins.fall[i];
            else
                detect[i] = ~pins.level_n[i];
        end
    end

    // flag update: clear beats a detection in the same cycle
    always_comb
    begin
        flag_next = flag_reg;
        for (int i = 0; i < `EIDA_NUM_IRQ; i++)
        begin
            if (flag_clr[i])
                flag_next[i] = 1'b0;
            else if (detect[i])
                flag_next[i] = 1'b1;
        end
    end

    // flag storage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flag_reg <= `EIDA_FLAG_RST;
        else
            flag_reg <= flag_next;
    end

    // a fall while the flag stands: sticky overrun, clear beats set
    always_comb
    begin
        overrun_next = overrun_reg;
        for (int i = 0; i < `EIDA_NUM_IRQ; i++)
        begin
            if (flag_reg[i] && !flag_clr[i] && pins.fall[i])
                overrun_next[i] = 1'b1;
            else if (flag_clr[i])
                overrun_next[i] = 1'b0;
        end
    end

    // overrun storage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            overrun_reg <= `EIDA_FLAG_RST;
        else
            overrun_reg <= overrun_next;
    end

    // pending interrupts per consumer
    assign cpu_pend = flag_reg & cpu_irq_enable;
    assign dma_pend = flag_reg & dma_irq_enable;

    // cpu view changes only at a fetch boundary
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cpu_req_reg <= 1'b0;
            cpu_id_reg  <= '0;
        end
        else if (cpu_fetch_boundary)
        begin
            cpu_req_reg <= eida_any(cpu_pend);
            cpu_id_reg  <= eida_first(cpu_pend);
        end
    end

    // dma view changes only at its fetch boundary
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dma_req_reg <= 1'b0;
            dma_id_reg  <= '0;
        end
        else if (dma_fetch_boundary)
        begin
            dma_req_reg <= eida_any(dma_pend);
            dma_id_reg  <= eida_first(dma_pend);
        end
    end

    // acknowledge sequencer: low from decode start to read start
    always_comb
    begin
        ack_state_next = ack_state_reg;
        strobe_n_next  = strobe_n_reg;
        case (ack_state_reg)
            eida_pkg::EIDA_ACK_IDLE:
            begin
                if (ack_decode_start)
                begin
                    ack_state_next = eida_pkg::EIDA_ACK_LOW;
                    strobe_n_next  = 1'b0;
                end
            end
            eida_pkg::EIDA_ACK_LOW:
            begin
                if (ack_read_start)
                begin
                    ack_state_next = eida_pkg::EIDA_ACK_IDLE;
                    strobe_n_next  = 1'b1;
                end
            end
            default:
            begin
                ack_state_next = eida_pkg::EIDA_ACK_IDLE;
                strobe_n_next  = 1'b1;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ack_state_reg <= eida_pkg::EIDA_ACK_IDLE;
        else
            ack_state_reg <= ack_state_next;
    end

    // strobe output flop, idle high
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            strobe_n_reg <= 1'b1;
        else
            strobe_n_reg <= strobe_n_next;
    end

    // outputs
    assign irq_flag         = flag_reg;
    assign irq_overrun      = overrun_reg;
    assign cpu_irq_req      = cpu_req_reg;
    assign cpu_irq_id       = cpu_id_reg;
    assign dma_irq_req      = dma_req_reg;
    assign dma_irq_id       = dma_id_reg;
    assign irq_ack_strobe_n = strobe_n_reg;

endmodule : eida_top

// >>> include/eida_defines.svh
// constants for the external interrupt detect and acknowledge block
`ifndef EIDA_DEFINES_SVH
`define EIDA_DEFINES_SVH

// number of active-low request pins
`define EIDA_NUM_IRQ        4
// flip-flops in the pin synchroniser
`define EIDA_SYNC_STAGES    2
// width of an interrupt index
`define EIDA_ID_W           2
// reset value of the per-pin sample history (pins idle high)
`define EIDA_SAMPLE_RST     4'h0f
// reset value of the flags
`define EIDA_FLAG_RST       4'h0
// acknowledge strobe state codes, one-hot
`define EIDA_ACK_IDLE       2'h1
`define EIDA_ACK_LOW        2'h2
// least phase-clock cycles from a flag clear to its next set
`define EIDA_REARM_CYC      2

`endif

// >>> include/eida_pkg.sv
// types for the external interrupt detect and acknowledge block
`include "eida_defines.svh"

package eida_pkg;

    // one bit per request pin
    typedef logic [`EIDA_NUM_IRQ-1:0] eida_vec_t;

    // index of a request pin
    typedef logic [`EIDA_ID_W-1:0] eida_id_t;

    // acknowledge strobe sequencer
    typedef enum logic [1:0] {
        EIDA_ACK_IDLE = `EIDA_ACK_IDLE,
        EIDA_ACK_LOW  = `EIDA_ACK_LOW
    } eida_ack_e;

endpackage : eida_pkg

// >>> include/eida_pin_if.sv
// carrier between the pin sampler and the flag logic
`timescale 1ns/100ps

interface eida_pin_if;

    // synchronised pin levels, low means request
    eida_pkg::eida_vec_t level_n;
    // one-cycle pulse on a sampled falling transition
    eida_pkg::eida_vec_t fall;

    modport sampler
    (
        output level_n,
        output fall
    );

    modport flags
    (
        input level_n,
        input fall
    );

endinterface : eida_pin_if

// >>> core/eida_sampler.sv
// two-stage pin synchroniser and falling-transition detector
`timescale 1ns/100ps
`include "eida_defines.svh"

module eida_sampler
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire eida_pkg::eida_vec_t ext_irq_n,
    eida_pin_if.sampler              pins
);

    eida_pkg::eida_vec_t meta_reg;
    eida_pkg::eida_vec_t sync_reg;
    eida_pkg::eida_vec_t prev_reg;

    // pins are asynchronous: two flops before any logic looks at them
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= `EIDA_SAMPLE_RST;
            sync_reg <= `EIDA_SAMPLE_RST;
        end
        else
        begin
            meta_reg <= ext_irq_n;
            sync_reg <= meta_reg;
        end
    end

    // previous sample, for the transition detector
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prev_reg <= `EIDA_SAMPLE_RST;
        else
            prev_reg <= sync_reg;
    end

    // a fall is high before, low now: one detection per transition
    assign pins.fall    = prev_reg & ~sync_reg;
    assign pins.level_n = sync_reg;

endmodule : eida_sampler

// >>> dv/eida_top_assertions.sv
// assertions on the detect and acknowledge block ports
`timescale 1ns/100ps

module eida_top_assertions
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire eida_pkg::eida_vec_t ext_irq_n,
    input wire eida_pkg::eida_vec_t edge_detect_select,
    input wire eida_pkg::eida_vec_t flag_clr,
    input wire eida_pkg::eida_vec_t cpu_irq_enable,
    input wire logic                cpu_fetch_boundary,
    input wire logic                ack_decode_start,
    input wire logic                ack_read_start,
    input wire eida_pkg::eida_vec_t irq_flag,
    input wire logic                cpu_irq_req,
    input wire logic                irq_ack_strobe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // strobe low on decode, high on read, never falls on its own
    AST_ACK_LOW:
        assert property (ack_decode_start && irq_ack_strobe_n
            |=> !irq_ack_strobe_n) else $error("strobe stayed high");
    AST_ACK_HIGH:
        assert property (ack_read_start && !irq_ack_strobe_n
            |=> irq_ack_strobe_n) else $error("strobe stayed low");
    AST_ACK_ONLY:
        assert property ($fell(irq_ack_strobe_n) |-> $past(ack_decode_start))
            else $error("strobe fell without decode");

    // flag set and clear against the sampled pins
    AST_CLR_WINS:
        assert property (flag_clr != '0 |=> (irq_flag & $past(flag_clr)) == '0)
            else $error("flag survived its clear");
    AST_NO_FALSE:
        assert property ((irq_flag & ~$past(irq_flag) & $past(ext_irq_n, 3))
            == '0) else $error("flag set from a high sample");
    AST_EDGE_ONE:
        assert property ((irq_flag & ~$past(irq_flag)
            & $past(edge_detect_select) & ~$past(ext_irq_n, 4)) == '0)
            else $error("edge flag without a falling transition");
    AST_LEVEL_SET:
        assert property ((~$past(ext_irq_n, 3) & ~$past(edge_detect_select)
            & ~$past(flag_clr) & ~irq_flag) == '0)
            else $error("level request not flagged");

    // cpu request latched at the fetch boundary
    AST_CPU_TAKE:
        assert property (cpu_fetch_boundary |=>
            cpu_irq_req == |$past(irq_flag & cpu_irq_enable))
            else $error("cpu request wrong after boundary");
endmodule : eida_top_assertions

// >>> dv/eida_irq_src.sv
// model of the external request sources, pins pulled up when idle
`timescale 1ns/100ps

module eida_irq_src
(
    input  wire logic                clk,
    input  wire eida_pkg::eida_vec_t fire,
    input  wire logic [2:0]          len,
    output eida_pkg::eida_vec_t      ext_irq_n
);
    logic [2:0] cnt_reg;

    initial ext_irq_n = '1;
    initial cnt_reg = 3'h0;

    // chosen pins low across len sampling edges, then released high
    always @(negedge clk)
    begin
        if (fire != '0)
        begin
            ext_irq_n <= ~fire;
            cnt_reg   <= len;
        end
        else if (cnt_reg > 3'h1)
            cnt_reg <= cnt_reg - 3'h1;
        else
        begin
            cnt_reg   <= 3'h0;
            ext_irq_n <= '1;
        end
    end
endmodule : eida_irq_src

// >>> dv/testbench.sv
// self-checking bench for the detect and acknowledge block
`timescale 1ns/100ps

module testbench;
    logic                clk, sys_rst, cpu_b, dma_b, dec, rd, creq, dreq;
    logic                ack_n;
    logic [2:0]          len;
    eida_pkg::eida_vec_t irq_n, sel, clr, cen, den, fire, flag, v, e, ovr;
    eida_pkg::eida_id_t  cid, did;
    int                  num_errors, tests_run, seed, i, m;

    eida_irq_src src
    (
        .clk(clk), .fire(fire), .len(len), .ext_irq_n(irq_n)
    );

    eida_top #(.NUM_IRQ(4)) dut
    (
        .clk(clk), .sys_rst(sys_rst), .ext_irq_n(irq_n),
        .edge_detect_select(sel), .flag_clr(clr), .cpu_irq_enable(cen),
        .dma_irq_enable(den), .cpu_fetch_boundary(cpu_b),
        .dma_fetch_boundary(dma_b), .ack_decode_start(dec),
        .ack_read_start(rd), .irq_flag(flag), .irq_overrun(ovr),
        .cpu_irq_req(creq), .cpu_irq_id(cid), .dma_irq_req(dreq),
        .dma_irq_id(did), .irq_ack_strobe_n(ack_n)
    );

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic note(input logic ok, input logic [3:0] g, x);
        tests_run++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask : note

    task automatic chk_vec(input eida_pkg::eida_vec_t g, x);
        note(g === x, g, x);
    endtask : chk_vec

    task automatic chk_id(input eida_pkg::eida_id_t g, x);
        note(g === x, {2'h0, g}, {2'h0, x});
    endtask : chk_id

    task automatic chk_bit(input logic g, x);
        note(g === x, {3'h0, g}, {3'h0, x});
    endtask : chk_bit

    function automatic eida_pkg::eida_id_t low_id(input eida_pkg::eida_vec_t a);
        low_id = '0;
        for (int k = 3; k >= 0; k--)
            if (a[k])
                low_id = k[1:0];
    endfunction : low_id

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic pulse(input eida_pkg::eida_vec_t a, input logic [2:0] l);
        fire <= a;
        len  <= l;
        cyc(1);
        fire <= '0;
    endtask : pulse

    task automatic clear(input eida_pkg::eida_vec_t a);
        clr <= a;
        cyc(1);
        clr <= '0;
    endtask : clear

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // main sequence
    initial
    begin
        seed = 94763;
        num_errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        {cpu_b, dma_b, dec, rd} = 4'h0;
        {sel, clr, cen, den, fire} = '0;
        len = 3'h0;
        cyc(6);
        sys_rst <= 1'b0;
        cyc(3);
        // each pin in level then edge mode, long low pulse
        for (m = 0; m < 2; m++)
        begin
            sel <= {4{m[0]}};
            cyc(2);
            for (i = 0; i < 4; i++)
            begin
                pulse(4'h1 << i, 3'h7);
                cyc(2);
                chk_vec(flag, '0);
                cyc(1);
                chk_vec(flag, 4'h1 << i);
                clear(4'h1 << i);
                chk_vec(flag, '0);
                cyc(2);
                chk_vec(flag, m ? 4'h0 : 4'h1 << i);
                cyc(4);
                clear('1);
            end
            $display("test mode %0d done", m);
        end
        // edge mode: a second fall while the flag stands marks an overrun
        pulse(4'h2, 3'h2);
        cyc(4);
        chk_vec(ovr, '0);
        pulse(4'h2, 3'h2);
        cyc(4);
        chk_vec(ovr, 4'h2);
        chk_vec(flag, 4'h2);
        clear('1);
        chk_vec(ovr, '0);
        $display("test overrun done");
        // random one-shot requests taken at fetch boundaries
        sel <= '0;
        for (i = 0; i < 8; i++)
        begin
            v = 4'($random(seed));
            e = 4'($random(seed));
            pulse(v, 3'h1);
            cyc(3);
            chk_vec(flag, v);
            cen <= e;
            den <= ~e;
            {cpu_b, dma_b} <= 2'h3;
            cyc(1);
            {cpu_b, dma_b} <= 2'h0;
            chk_bit(creq, |(v & e));
            chk_bit(dreq, |(v & ~e));
            if (|(v & e))
                chk_id(cid, low_id(v & e));
            if (|(v & ~e))
                chk_id(did, low_id(v & ~e));
            clear('1);
            cyc(2);
            chk_vec(flag, '0);
            chk_bit(creq, |(v & e));
        end
        $display("test boundary done");
        // strobe: stray read, held decode, then read
        for (i = 0; i < 2; i++)
        begin
            rd <= 1'b1;
            cyc(1);
            rd <= 1'b0;
            chk_bit(ack_n, 1'b1);
            dec <= 1'b1;
            cyc(1);
            chk_bit(ack_n, 1'b0);
            cyc(1);
            dec <= 1'b0;
            chk_bit(ack_n, 1'b0);
            rd <= 1'b1;
            cyc(1);
            rd <= 1'b0;
            chk_bit(ack_n, 1'b1);
            cyc(1);
        end
        $display("test strobe done");
        conclude();
    end
endmodule : testbench

bind eida_top eida_top_assertions chk
(
    .clk                (clk),
    .sys_rst            (sys_rst),
    .ext_irq_n          (ext_irq_n),
    .edge_detect_select (edge_detect_select),
    .flag_clr           (flag_clr),
    .cpu_irq_enable     (cpu_irq_enable),
    .cpu_fetch_boundary (cpu_fetch_boundary),
    .ack_decode_start   (ack_decode_start),
    .ack_read_start     (ack_read_start),
    .irq_flag           (irq_flag),
    .cpu_irq_req        (cpu_irq_req),
    .irq_ack_strobe_n   (irq_ack_strobe_n)
);
